// ==== src/ccp_control_port.sv ====
// Codec control port: 3-wire write port and I2C slave over a register bank.
`timescale 1ns/1ps
// Operation
// - Strap low selects the 3-wire port, strap high selects the I2C slave.
// - 3-wire frame: chip id 01, write bit 1, 5-bit index, 8-bit payload.
// - 3-wire bits are sampled on the rising control clock edge.
// - The payload is committed after the sixteenth rising control clock.
// - Power-down low holds every register at its reset value.
// - I2C runs as fast-mode slave up to 400 kHz.
// - Slave address is 001000 plus the address strap, then direction.
// - Only a matching slave address is acknowledged and served.
// - Every byte sent to a matching slave address is acknowledged by the device.
// - Write pointer increments per data byte and wraps past 13H to 00H.
// - Master acknowledge on read data sends the next byte, same wrap.
// - Pointer holds last access plus one; current reads use it.
// - No acknowledge then stop ends transmission and releases data.
// - Data changes only while clock is low, except start and stop.
// - All register writes are ignored while power-down is low.
module ccp_control_port (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             power_down_n,
  input  wire logic             i2c_select,
  input  wire logic             address_strap_pin,
  input  wire logic             chip_select_n,
  input  wire logic             control_clock,
  input  wire logic             control_data_in,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  output ccp_pkg::ccp_bank_t    reg_bank
);
  import ccp_pkg::*;

  // ****************************************************************
  // Link domain: 3-wire shift logic on the control clock
  // ****************************************************************
  typedef struct packed {
    logic [14:0] shift;
    logic [15:0] word;
    logic        tgl;
  } ccp_lnk_s;

  ccp_lnk_s   lnk_q;
  ccp_lnk_s   lnk_d;
  logic [4:0] bit_cnt_q;
  logic       frame_clear;

  // The control clock stands still between frames, so the bit count is
  // cleared by chip select itself rather than by a later clock edge.
  assign frame_clear = ~rstn | chip_select_n;

  // Bit counter saturates at sixteen; extra clocks in a frame are ignored.
  always_ff @(posedge control_clock or posedge frame_clear) begin
    if (frame_clear) begin
      bit_cnt_q <= 5'h00;
    end else if (bit_cnt_q < CCP_FRAME_BITS) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // Shift in MSB first and capture the whole frame on the sixteenth bit.
  always_comb begin
    lnk_d = lnk_q;
    if (bit_cnt_q < CCP_FRAME_BITS) begin
      lnk_d.shift = {lnk_q.shift[13:0], control_data_in};
      if (bit_cnt_q == CCP_FRAME_BITS - 5'h01) begin
        lnk_d.word = {lnk_q.shift, control_data_in};
        lnk_d.tgl  = ~lnk_q.tgl;
      end
    end
  end

  // The captured word stays still for a whole frame after the toggle,
  // which gives the system side ample time to take it.
  always_ff @(posedge control_clock or negedge rstn) begin
    if (!rstn) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  // ****************************************************************
  // System domain: synchronisers, I2C slave and register bank
  // ****************************************************************
  typedef struct packed {
    logic [1:0] pdn_s;
    logic [1:0] sel_s;
    logic [1:0] cad_s;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] tgl_s;
    ccp_i2c_e   st;
    logic [1:0] phase;
    logic       rw;
    logic       mack;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [4:0] ptr;
    logic       sda_oe;
    logic       sda_o;
    ccp_bank_t  bank;
  } ccp_sys_s;

  ccp_sys_s   s_q;
  ccp_sys_s   s_d;
  logic       i2c_mode;
  logic       powered;
  logic [6:0] own_addr;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       frame_new;
  logic [4:0] ptr_next;
  logic [4:0] fr_index;
  logic [7:0] fr_data;
  logic [7:0] rd_byte;

  // Level and edge views of the synchronised pins; stage 0 feeds stage 1 only.
  assign i2c_mode   = s_q.sel_s[1];
  assign powered    = s_q.pdn_s[1];
  assign own_addr   = {CCP_SLAVE_ADDR_HIGH, s_q.cad_s[1]};
  assign scl_rise   = s_q.scl_s[1] & ~s_q.scl_s[2];
  assign scl_fall   = ~s_q.scl_s[1] & s_q.scl_s[2];
  assign start_seen = s_q.scl_s[1] & s_q.scl_s[2] &
                      ~s_q.sda_s[1] & s_q.sda_s[2];
  assign stop_seen  = s_q.scl_s[1] & s_q.scl_s[2] &
                      s_q.sda_s[1] & ~s_q.sda_s[2];
  assign frame_new  = s_q.tgl_s[1] ^ s_q.tgl_s[2];
  assign fr_index   = lnk_q.word[12:8];
  assign fr_data    = lnk_q.word[7:0];

  // Pointer step with the wrap past the last register.
  assign ptr_next = (s_q.ptr == CCP_ADDR_LAST) ? CCP_ADDR_FIRST :
                    s_q.ptr + 5'h01;

  // Addresses beyond the bank read as zero.
  assign rd_byte = (s_q.ptr <= CCP_ADDR_LAST) ? s_q.bank[s_q.ptr] : 8'h00;

  // Next state of the whole system side.
  always_comb begin
    s_d       = s_q;
    s_d.pdn_s = {s_q.pdn_s[0], power_down_n};
    s_d.sel_s = {s_q.sel_s[0], i2c_select};
    s_d.cad_s = {s_q.cad_s[0], address_strap_pin};
    s_d.scl_s = {s_q.scl_s[1:0], scl_in};
    s_d.sda_s = {s_q.sda_s[1:0], sda_in};
    s_d.tgl_s = {s_q.tgl_s[1:0], lnk_q.tgl};
    s_d.sda_o = 1'b0;

    // 3-wire commit: only in 3-wire mode and only for a valid header.
    if (frame_new && !i2c_mode && powered &&
        lnk_q.word[15:14] == CCP_FRAME_CHIP_ID &&
        lnk_q.word[13] == CCP_FRAME_WRITE &&
        fr_index <= CCP_ADDR_LAST) begin
      s_d.bank[fr_index] = fr_data & ccp_wmask(fr_index);
    end

    // I2C slave engine; it stays idle and released in 3-wire mode.
    if (!i2c_mode) begin
      s_d.st     = CCP_IDLE;
      s_d.sda_oe = 1'b0;
    end else if (stop_seen) begin
      s_d.st     = CCP_IDLE;
      s_d.sda_oe = 1'b0;
    end else if (start_seen) begin
      // A repeated start restarts with the address byte.
      s_d.st     = CCP_RX;
      s_d.phase  = CCP_PHASE_ADDR;
      s_d.cnt    = 4'h0;
      s_d.sda_oe = 1'b0;
    end else begin
      unique case (s_q.st)
        CCP_IDLE: begin
          s_d.sda_oe = 1'b0;
        end
        CCP_RX: begin
          if (scl_rise) begin
            s_d.sh  = {s_q.sh[6:0], s_q.sda_s[1]};
            s_d.cnt = s_q.cnt + 4'h1;
          end else if (scl_fall && s_q.cnt == CCP_BYTE_BITS) begin
            s_d.st     = CCP_ACK;
            s_d.sda_oe = 1'b1;
            if (s_q.phase == CCP_PHASE_ADDR) begin
              if (s_q.sh[7:1] != own_addr) begin
                s_d.st     = CCP_IDLE;
                s_d.sda_oe = 1'b0;
              end
              s_d.rw = s_q.sh[0];
            end else if (s_q.phase == CCP_PHASE_REG) begin
              s_d.ptr = s_q.sh[4:0];
            end else begin
              if (powered && s_q.ptr <= CCP_ADDR_LAST) begin
                s_d.bank[s_q.ptr] = s_q.sh & ccp_wmask(s_q.ptr);
              end
              s_d.ptr = ptr_next;
            end
          end
        end
        CCP_ACK: begin
          // Hold the acknowledge through the master's ninth pulse.
          if (scl_fall) begin
            s_d.cnt = 4'h0;
            if (s_q.phase == CCP_PHASE_ADDR && s_q.rw) begin
              s_d.st     = CCP_TX;
              s_d.sh     = rd_byte;
              s_d.ptr    = ptr_next;
              s_d.sda_oe = ~rd_byte[7];
            end else begin
              s_d.st     = CCP_RX;
              s_d.sda_oe = 1'b0;
              s_d.phase  = (s_q.phase == CCP_PHASE_ADDR) ?
                           CCP_PHASE_REG : CCP_PHASE_DATA;
            end
          end
        end
        CCP_TX: begin
          // Bits change only after a falling clock edge.
          if (scl_fall) begin
            if (s_q.cnt == CCP_BYTE_BITS - 4'h1) begin
              s_d.st     = CCP_RACK;
              s_d.sda_oe = 1'b0;
            end else begin
              s_d.sh     = {s_q.sh[6:0], 1'b0};
              s_d.cnt    = s_q.cnt + 4'h1;
              s_d.sda_oe = ~s_q.sh[6];
            end
          end
        end
        CCP_RACK: begin
          if (scl_rise) begin
            s_d.mack = ~s_q.sda_s[1];
          end else if (scl_fall) begin
            s_d.cnt = 4'h0;
            if (s_q.mack) begin
              s_d.st     = CCP_TX;
              s_d.sh     = rd_byte;
              s_d.ptr    = ptr_next;
              s_d.sda_oe = ~rd_byte[7];
            end else begin
              s_d.st     = CCP_IDLE;
              s_d.sda_oe = 1'b0;
            end
          end
        end
        default: begin
          s_d.st     = CCP_IDLE;
          s_d.sda_oe = 1'b0;
        end
      endcase
    end

    // Power-down wins over every write path in the same cycle.
    if (!powered) begin
      s_d.bank = ccp_reset_bank();
    end
  end

  // Single register stage for the system side.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q      <= '0;
      s_q.bank <= ccp_reset_bank();
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the system-side flops.
  assign sda_out  = s_q.sda_o;
  assign sda_oe   = s_q.sda_oe;
  assign reg_bank = s_q.bank;

endmodule

// ==== src/ccp_pkg.sv ====
// Constants, register map and types of the codec control port.
package ccp_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned CCP_REG_COUNT = 20;
  localparam logic [4:0] CCP_ADDR_POWER_MANAGEMENT     = 5'h00;
  localparam logic [4:0] CCP_ADDR_PLL_CONTROL          = 5'h01;
  localparam logic [4:0] CCP_ADDR_CLOCK_CONTROL        = 5'h02;
  localparam logic [4:0] CCP_ADDR_MODE_CONTROL_FIRST   = 5'h03;
  localparam logic [4:0] CCP_ADDR_MODE_CONTROL_SECOND  = 5'h04;
  localparam logic [4:0] CCP_ADDR_LEFT_DIGITAL_VOLUME  = 5'h05;
  localparam logic [4:0] CCP_ADDR_RIGHT_DIGITAL_VOLUME = 5'h06;
  localparam logic [4:0] CCP_ADDR_HEADPHONE_MIX_FIRST  = 5'h07;
  localparam logic [4:0] CCP_ADDR_LINE_MIX_FIRST       = 5'h08;
  localparam logic [4:0] CCP_ADDR_LINE_VOLUME          = 5'h09;
  localparam logic [4:0] CCP_ADDR_RESERVED_A           = 5'h0a;
  localparam logic [4:0] CCP_ADDR_RESERVED_B           = 5'h0b;
  localparam logic [4:0] CCP_ADDR_RESERVED_C           = 5'h0c;
  localparam logic [4:0] CCP_ADDR_HEADPHONE_MIX_SECOND = 5'h0d;
  localparam logic [4:0] CCP_ADDR_HEADPHONE_VOLUME     = 5'h0e;
  localparam logic [4:0] CCP_ADDR_LINE_MIX_SECOND      = 5'h0f;
  localparam logic [4:0] CCP_ADDR_MONO_MIXING          = 5'h10;
  localparam logic [4:0] CCP_ADDR_DIFFERENTIAL_SELECT  = 5'h11;
  localparam logic [4:0] CCP_ADDR_MONO_OUT_MIX         = 5'h12;
  localparam logic [4:0] CCP_ADDR_MONO_OUT_VOLUME      = 5'h13;
  localparam logic [4:0] CCP_ADDR_LAST  = CCP_ADDR_MONO_OUT_VOLUME;
  localparam logic [4:0] CCP_ADDR_FIRST = CCP_ADDR_POWER_MANAGEMENT;

  // Non-zero reset values; every other register resets to zero.
  localparam logic [7:0] CCP_RST_PLL_CONTROL         = 8'h80;
  localparam logic [7:0] CCP_RST_MODE_CONTROL_FIRST  = 8'h02;
  localparam logic [7:0] CCP_RST_MODE_CONTROL_SECOND = 8'h21;

  // Writable bits; the others always read as zero.
  localparam logic [7:0] CCP_WMASK_FULL          = 8'hff;
  localparam logic [7:0] CCP_WMASK_CLOCK_CONTROL = 8'hbf;
  localparam logic [7:0] CCP_WMASK_TOP_ZERO      = 8'h7f;
  localparam logic [7:0] CCP_WMASK_LINE_VOLUME   = 8'h0f;
  localparam logic [7:0] CCP_WMASK_MONO_MIXING   = 8'h3f;
  localparam logic [7:0] CCP_WMASK_DIFF_SELECT   = 8'h07;
  localparam logic [7:0] CCP_WMASK_NONE          = 8'h00;

  // ****************************************************************
  // Link framing
  // ****************************************************************
  localparam logic [5:0] CCP_SLAVE_ADDR_HIGH = 6'h08;
  localparam logic [1:0] CCP_FRAME_CHIP_ID   = 2'h1;
  localparam logic       CCP_FRAME_WRITE     = 1'h1;
  localparam logic [4:0] CCP_FRAME_BITS      = 5'h10;
  localparam logic [3:0] CCP_BYTE_BITS       = 4'h8;
  localparam logic [1:0] CCP_PHASE_ADDR      = 2'h0;
  localparam logic [1:0] CCP_PHASE_REG       = 2'h1;
  localparam logic [1:0] CCP_PHASE_DATA      = 2'h2;

  typedef logic [CCP_REG_COUNT-1:0][7:0] ccp_bank_t;

  typedef enum logic [2:0] {
    CCP_IDLE = 3'b000,
    CCP_RX   = 3'b001,
    CCP_ACK  = 3'b010,
    CCP_TX   = 3'b011,
    CCP_RACK = 3'b100
  } ccp_i2c_e;

  // Reset image of the whole register bank.
  function automatic ccp_bank_t ccp_reset_bank();
    ccp_bank_t b;
    b = '0;
    b[CCP_ADDR_PLL_CONTROL]         = CCP_RST_PLL_CONTROL;
    b[CCP_ADDR_MODE_CONTROL_FIRST]  = CCP_RST_MODE_CONTROL_FIRST;
    b[CCP_ADDR_MODE_CONTROL_SECOND] = CCP_RST_MODE_CONTROL_SECOND;
    return b;
  endfunction

  // Mask of the bits that a write may change at one address.
  function automatic logic [7:0] ccp_wmask(input logic [4:0] a);
    logic [7:0] m;
    m = CCP_WMASK_FULL;
    if (a > CCP_ADDR_LAST) begin
      m = CCP_WMASK_NONE;
    end else if (a >= CCP_ADDR_RESERVED_A && a <= CCP_ADDR_RESERVED_C) begin
      m = CCP_WMASK_NONE;
    end else if (a == CCP_ADDR_CLOCK_CONTROL) begin
      m = CCP_WMASK_CLOCK_CONTROL;
    end else if (a == CCP_ADDR_MODE_CONTROL_FIRST ||
                 a == CCP_ADDR_LINE_MIX_FIRST ||
                 a == CCP_ADDR_HEADPHONE_VOLUME ||
                 a == CCP_ADDR_MONO_OUT_VOLUME) begin
      m = CCP_WMASK_TOP_ZERO;
    end else if (a == CCP_ADDR_LINE_VOLUME) begin
      m = CCP_WMASK_LINE_VOLUME;
    end else if (a == CCP_ADDR_MONO_MIXING) begin
      m = CCP_WMASK_MONO_MIXING;
    end else if (a == CCP_ADDR_DIFFERENTIAL_SELECT) begin
      m = CCP_WMASK_DIFF_SELECT;
    end
    return m;
  endfunction

endpackage

// ==== tb/ccp_control_port_sva.sv ====
// Concurrent checks on the ports of the codec control port.
`timescale 1ns/1ps
module ccp_control_port_sva (
  input wire logic               sys_clk,
  input wire logic               rstn,
  input wire logic               power_down_n,
  input wire logic               i2c_select,
  input wire logic               chip_select_n,
  input wire logic               scl_in,
  input wire logic               sda_oe,
  input wire ccp_pkg::ccp_bank_t reg_bank
);
  import ccp_pkg::*;
  // ****************************************************************
  // Checks, all in the system clock domain
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_reset_image;
    !$past(rstn) |-> reg_bank[3] == CCP_RST_MODE_CONTROL_FIRST;
  endproperty
  a_reset_image: assert property (p_reset_image)
    else $error("bank not at reset image after reset");
  property p_pd_hold;
    !power_down_n [*5] |-> reg_bank[1] == CCP_RST_PLL_CONTROL &&
      reg_bank[4] == CCP_RST_MODE_CONTROL_SECOND && reg_bank[5] == 8'h00;
  endproperty
  a_pd_hold: assert property (p_pd_hold)
    else $error("bank not held during power-down");
  property p_pd_stable;
    !power_down_n [*5] |=> $stable(reg_bank);
  endproperty
  a_pd_stable: assert property (p_pd_stable)
    else $error("bank changed during power-down");
  // Without a frame, power-down or I2C the bank must not move.
  property p_quiet;
    (chip_select_n && power_down_n && !i2c_select) [*8] |=> $stable(reg_bank);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("bank changed with no frame");
  property p_wire3_mode;
    !i2c_select [*4] |-> !sda_oe;
  endproperty
  a_wire3_mode: assert property (p_wire3_mode)
    else $error("data line driven in 3-wire mode");
  property p_oe_scl_low;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in);
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data line moved while clock high");
  property p_oe_hold;
    $rose(sda_oe) |=> sda_oe [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("acknowledge too short");
  property p_fixed_zero;
    reg_bank[10] == 8'h00 && reg_bank[9][7:4] == 4'h0 &&
      reg_bank[17][7:3] == 5'h00;
  endproperty
  a_fixed_zero: assert property (p_fixed_zero)
    else $error("fixed zero bits set");
endmodule

bind ccp_control_port ccp_control_port_sva u_sva (
  .sys_clk, .rstn, .power_down_n, .i2c_select, .chip_select_n,
  .scl_in, .sda_oe, .reg_bank
);

// ==== tb/ccp_host_model.sv ====
// Host model: 3-wire frame sender and bit-banged I2C master.
`timescale 1ns/1ps
module ccp_host_model (
  output logic      chip_select_n,
  output logic      control_clock,
  output logic      control_data_in,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  // ****************************************************************
  // Timing and bit tasks
  // ****************************************************************
  localparam int H = 625;

  initial begin
    chip_select_n = 1'b1;
    control_clock = 1'b1;
    control_data_in = 1'b0;
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One frame MSB first; the clock stands still between frames.
  // A 200 ns period keeps the link clock at the 5 MHz ceiling.
  task automatic frame(input logic [15:0] f);
    #37.3;
    chip_select_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      control_clock = 1'b0;
      control_data_in = f[i];
      #100 control_clock = 1'b1;
      #100;
    end
    // Released data shows the inverse so a stale bit never looks valid.
    control_data_in = ~control_data_in;
    #40 chip_select_n = 1'b1;
    #200;
  endtask

  // Data moves only in the clock low phase.
  task automatic bit_out(input logic b);
    sda_low = ~b;
    #H scl = 1'b1;
    #(2*H) scl = 1'b0;
    #H;
  endtask

  task automatic bit_in(output logic b);
    sda_low = 1'b0;
    #H scl = 1'b1;
    #H b = sda_line;
    #H scl = 1'b0;
    #H;
  endtask

  // Works from idle and as a repeated start after an acknowledge.
  task automatic start();
    sda_low = 1'b0;
    #H scl = 1'b1;
    #H sda_low = 1'b1;
    #H scl = 1'b0;
    #H;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #H scl = 1'b1;
    #H sda_low = 1'b0;
    #H;
  endtask

  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    bit_in(a);
    ack = ~a;
  endtask

  task automatic byte_in(output logic [7:0] d, input logic more);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(~more);
  endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking testbench of the codec control port.
`timescale 1ns/1ps
module tb;
  import ccp_pkg::*;
  logic       sys_clk;
  logic       rstn;
  logic       power_down_n;
  logic       i2c_select;
  logic       address_strap_pin;
  logic       chip_select_n;
  logic       control_clock;
  logic       control_data_in;
  logic       scl_in;
  logic       sda_low;
  logic       sda_in;
  logic       sda_out;
  logic       sda_oe;
  ccp_bank_t  reg_bank;
  logic       ack;
  logic [7:0] rd;
  logic [7:0] e;
  int         err_count = 0;
  int         num_checks = 0;

  // Open-drain data line with a pull-up.
  assign sda_in = !(sda_low || sda_oe);

  ccp_host_model u_host (
    .chip_select_n, .control_clock, .control_data_in,
    .scl(scl_in), .sda_low, .sda_line(sda_in)
  );
  ccp_control_port u_dut (
    .sys_clk, .rstn, .power_down_n, .i2c_select, .address_strap_pin,
    .chip_select_n, .control_clock, .control_data_in, .scl_in, .sda_in,
    .sda_out, .sda_oe, .reg_bank
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic put(input logic [7:0] b, input logic exp_ack);
    u_host.byte_out(b, ack);
    check({7'h0, ack}, {7'h0, exp_ack});
  endtask

  task automatic get(input logic [7:0] exp, input logic more);
    u_host.byte_in(rd, more);
    check(rd, exp);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // A hang costs a mismatch and ends the run the usual way.
  initial begin
    repeat (95000) @(posedge sys_clk);
    err_count++;
    results();
  end

  initial begin
    rstn = 1'b0;
    power_down_n = 1'b1;
    i2c_select = 1'b0;
    address_strap_pin = 1'b1;
    cyc(12);
    rstn = 1'b1;
    cyc(6);
    for (int i = 0; i < 20; i++) begin
      e = i == 1 ? 8'h80 : i == 3 ? 8'h02 : i == 4 ? 8'h21 : 8'h00;
      check(reg_bank[i], e);
    end
    // 3-wire writes, the last index, and two refused frames.
    // Unused top bits are always sent as zero, as the host must.
    u_host.frame({2'b01, 1'b1, 5'h05, 8'ha5});
    check(reg_bank[5], 8'ha5);
    u_host.frame({2'b01, 1'b1, 5'h13, 8'h3c});
    check(reg_bank[19], 8'h3c);
    u_host.frame({2'b10, 1'b1, 5'h05, 8'h11});
    u_host.frame({2'b01, 1'b0, 5'h05, 8'h22});
    check(reg_bank[5], 8'ha5);
    cyc(1);
    power_down_n = 1'b0;
    cyc(8);
    check(reg_bank[5], 8'h00);
    u_host.frame({2'b01, 1'b1, 5'h06, 8'h5a});
    check(reg_bank[6], 8'h00);
    cyc(1);
    power_down_n = 1'b1;
    i2c_select = 1'b1;
    cyc(8);
    u_host.frame({2'b01, 1'b1, 5'h06, 8'h5a});
    check(reg_bank[6], 8'h00);
    // I2C burst write across the wrap point.
    u_host.start();
    put(8'h22, 1'b1);
    put(8'h12, 1'b1);
    put(8'h81, 1'b1);
    put(8'h02, 1'b1);
    put(8'h83, 1'b1);
    u_host.stop();
    check(reg_bank[18], 8'h81);
    check(reg_bank[19], 8'h02);
    check(reg_bank[0], 8'h83);
    // Current-address read of three bytes.
    u_host.start();
    put(8'h23, 1'b1);
    get(8'h80, 1'b1);
    get(8'h00, 1'b1);
    get(8'h02, 1'b0);
    u_host.stop();
    check({7'h0, sda_oe}, 8'h00);
    // Random read at the last register, wrapping to the first.
    u_host.start();
    put(8'h22, 1'b1);
    put(8'h13, 1'b1);
    u_host.start();
    put(8'h23, 1'b1);
    get(8'h02, 1'b1);
    get(8'h83, 1'b0);
    u_host.stop();
    // Foreign address, then the same address after the strap moves.
    u_host.start();
    put(8'h20, 1'b0);
    u_host.stop();
    cyc(1);
    address_strap_pin = 1'b0;
    cyc(8);
    u_host.start();
    put(8'h20, 1'b1);
    u_host.stop();
    // The data pin value is only ever a pull to ground.
    check({7'h0, sda_out}, 8'h00);
    results();
  end
endmodule
